// ### inc/wdt_pkg.sv
package watchdog_pkg;
    // ************************************************************
    // Bus carrier
    // ************************************************************
    localparam int ADR_W = 8;
    localparam int DAT_W = 32;
    localparam int SEL_W = 4;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [ADR_W-1:0] adr;
        logic [SEL_W-1:0] sel;
        logic [DAT_W-1:0] dat;
    } wb_req_s;

    // ************************************************************
    // Register map and fields
    // ************************************************************
    localparam logic [ADR_W-1:0] WATCHDOG_CONTROL_OFS = 8'h00;
    localparam int ON_BIT = 15;
    localparam int PS_LSB = 2;
    localparam int PS_MSB = 6;
    localparam int PS_W = 5;
    localparam int WIN_BIT = 1;
    localparam int CLR_BIT = 0;
    localparam int ON_LANE = 1;
    localparam int LOW_LANE = 0;
    localparam logic [DAT_W-1:0] IMPL_MASK = 32'h0000807E;
    localparam logic [PS_W-1:0] PS_RESET = 5'h00;
    localparam logic [PS_W-1:0] PS_MAX = 5'h14;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int CLK_MHZ = 200;
    localparam int TICK_TIME_US = 1000;
    localparam int TICK_CYCLES = TICK_TIME_US * CLK_MHZ;
    localparam int CNT_W = 32;
    localparam int TICK_W = 32;
    // Window opens for the last quarter of the period
    localparam int WIN_SHIFT = 2;
endpackage

// ### verilog/watchdog_control_logic.sv
`timescale 1ns/1ps
// Summary of operation
// - Software writing one to the enable bit starts the watchdog.
// - Writing zero stops it only if software enabled it; configuration enable persists.
// - Enable bit reads one when enabled by configuration or software.
// - Read-only five-bit postscale shadow in bits 6:2, loaded from configuration on the first clock after reset release.
// - Window-mode enable at bit 1, reset zero, selects windowed operation.
// - Writing one to clear bit 0 restarts the count from zero.
// - Writing zero to the clear bit does nothing.
// - Bits 31:16 and 14:7 ignore writes and read zero.
module watchdog_control_logic
#(
    parameter int TICK_CYCLES_P = watchdog_pkg::TICK_CYCLES
)
(
    input wire logic sys_clk, // 200 MHz clock
    input wire logic nrst, // Async reset, active low
    input wire watchdog_pkg::wb_req_s wb_req, // Wishbone request
    output logic [watchdog_pkg::DAT_W-1:0] wb_dat_o, // Wishbone read data
    output logic wb_ack_o, // Wishbone ack
    input wire logic config_enable, // Configuration-level enable
    input wire logic [watchdog_pkg::PS_W-1:0] configured_postscale, // Configured postscaler
    output logic watchdog_enabled, // Effective enable
    output logic window_mode, // Window mode selected
    output logic reset_request // Device reset request, held
);
    import watchdog_pkg::*;

    // ************************************************************
    // Bus slave
    // ************************************************************
    logic ack_reg, ack_next;
    logic [DAT_W-1:0] rdat_reg, rdat_next;
    logic hit, wr_acc, rd_acc;
    logic sw_on_reg, sw_on_next;
    logic win_reg, win_next;
    logic [PS_W-1:0] shadow_reg, shadow_next;
    logic load_pend_reg, load_pend_next;
    logic clear_req;

    assign hit = wb_req.adr == WATCHDOG_CONTROL_OFS;
    assign wr_acc = wb_req.cyc && wb_req.stb && !ack_reg && wb_req.we && hit;
    assign rd_acc = wb_req.cyc && wb_req.stb && !ack_reg && !wb_req.we && hit;
    assign watchdog_enabled = config_enable || sw_on_reg;
    assign window_mode = win_reg;
    assign clear_req = wr_acc && wb_req.sel[LOW_LANE] && wb_req.dat[CLR_BIT];

    always_comb begin
        ack_next = wb_req.cyc && wb_req.stb && !ack_reg;
        rdat_next = '0;
        if (rd_acc) begin
            rdat_next[ON_BIT] = watchdog_enabled;
            rdat_next[PS_MSB:PS_LSB] = shadow_reg;
            rdat_next[WIN_BIT] = win_reg;
            rdat_next = rdat_next & IMPL_MASK;
        end
        sw_on_next = sw_on_reg;
        win_next = win_reg;
        if (wr_acc && wb_req.sel[ON_LANE]) begin
            sw_on_next = wb_req.dat[ON_BIT];
        end
        if (wr_acc && wb_req.sel[LOW_LANE]) begin
            win_next = wb_req.dat[WIN_BIT];
        end
        // Shadow caught once after reset release; async reset takes constants only
        load_pend_next = 1'b0;
        shadow_next = load_pend_reg ? configured_postscale : shadow_reg;
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            ack_reg <= 1'b0;
            rdat_reg <= '0;
            sw_on_reg <= 1'b0;
            win_reg <= 1'b0;
            shadow_reg <= PS_RESET;
            load_pend_reg <= 1'b1;
        end else begin
            ack_reg <= ack_next;
            rdat_reg <= rdat_next;
            sw_on_reg <= sw_on_next;
            win_reg <= win_next;
            shadow_reg <= shadow_next;
            load_pend_reg <= load_pend_next;
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = rdat_reg;

    // ************************************************************
    // Time base and count
    // ************************************************************
    logic [TICK_W-1:0] tick_cnt_reg, tick_cnt_next;
    logic [CNT_W-1:0] count_reg, count_next;
    logic rst_req_reg, rst_req_next;
    logic tick;
    logic [PS_W-1:0] ps_eff;
    logic [CNT_W-1:0] period, win_open;

    assign tick = tick_cnt_reg == TICK_W'(TICK_CYCLES_P - 1);
    // Postscale above the maximum saturates, so the period never overflows
    assign ps_eff = (shadow_reg > PS_MAX) ? PS_MAX : shadow_reg;
    assign period = CNT_W'(1) << ps_eff;
    assign win_open = period - (period >> WIN_SHIFT);

    always_comb begin
        tick_cnt_next = tick ? '0 : tick_cnt_reg + TICK_W'(1);
        count_next = count_reg;
        rst_req_next = rst_req_reg;
        if (!watchdog_enabled) begin
            tick_cnt_next = '0;
            count_next = '0;
        end else if (clear_req) begin
            tick_cnt_next = '0;
            count_next = '0;
            if (win_reg && count_reg < win_open) begin
                rst_req_next = 1'b1;
            end
        end else if (tick) begin
            if (count_reg >= period - CNT_W'(1)) begin
                rst_req_next = 1'b1;
            end else begin
                count_next = count_reg + CNT_W'(1);
            end
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            tick_cnt_reg <= '0;
            count_reg <= '0;
            rst_req_reg <= 1'b0;
        end else begin
            tick_cnt_reg <= tick_cnt_next;
            count_reg <= count_next;
            rst_req_reg <= rst_req_next;
        end
    end

    assign reset_request = rst_req_reg;

    // ************************************************************
    // Checks
    // ************************************************************
    a_sw_start_on: assert property (@(posedge sys_clk) disable iff (!nrst)
        wr_acc && wb_req.sel[ON_LANE] && wb_req.dat[ON_BIT] |=> watchdog_enabled)
        else $error("software enable did not start watchdog");
    a_cfg_keeps_on: assert property (@(posedge sys_clk) disable iff (!nrst)
        wr_acc && wb_req.sel[ON_LANE] && !wb_req.dat[ON_BIT] && config_enable
        |=> sw_on_reg == 1'b0 && (watchdog_enabled || !config_enable))
        else $error("zero write mishandled with configuration enable");
    a_sw_stop_off: assert property (@(posedge sys_clk) disable iff (!nrst)
        wr_acc && wb_req.sel[ON_LANE] && !wb_req.dat[ON_BIT] |=> !sw_on_reg ##1 count_reg == 0
        || config_enable || $past(config_enable))
        else $error("software disable did not stop watchdog");
    a_on_readback: assert property (@(posedge sys_clk) disable iff (!nrst)
        rd_acc |=> wb_ack_o && wb_dat_o[ON_BIT] == $past(watchdog_enabled))
        else $error("enable readback wrong");
    a_shadow_load: assert property (@(posedge sys_clk) disable iff (!nrst)
        // Sampled nrst skips the edge at which reset is released
        nrst && load_pend_reg |=> shadow_reg == $past(configured_postscale) && !load_pend_reg)
        else $error("shadow not loaded after reset");
    a_shadow_hold: assert property (@(posedge sys_clk) disable iff (!nrst)
        !load_pend_reg |=> $stable(shadow_reg))
        else $error("shadow changed outside reset");
    a_window_write: assert property (@(posedge sys_clk) disable iff (!nrst)
        wr_acc && wb_req.sel[LOW_LANE] |=> window_mode == $past(wb_req.dat[WIN_BIT]))
        else $error("window bit not written");
    a_clear_restart: assert property (@(posedge sys_clk) disable iff (!nrst)
        clear_req |=> count_reg == 0 && tick_cnt_reg == 0)
        else $error("clear did not restart count");
    a_clear_zero: assert property (@(posedge sys_clk) disable iff (!nrst)
        wr_acc && wb_req.sel[LOW_LANE] && !wb_req.dat[CLR_BIT] && watchdog_enabled && !tick
        |=> count_reg == $past(count_reg))
        else $error("zero clear write changed count");
    a_unimpl_zero: assert property (@(posedge sys_clk) disable iff (!nrst)
        wb_ack_o |-> (wb_dat_o & ~IMPL_MASK) == 0)
        else $error("unimplemented bits read nonzero");
    // Registered ack gives every access exactly one wait state
    a_ack_answer: assert property (@(posedge sys_clk) disable iff (!nrst)
        wb_req.cyc && wb_req.stb && !wb_ack_o |=> wb_ack_o)
        else $error("request not acknowledged after one cycle");
    a_ack_pulse: assert property (@(posedge sys_clk) disable iff (!nrst)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    // Idle zeros on the data bus keep a shared read mux simple
    a_dat_idle: assert property (@(posedge sys_clk) disable iff (!nrst)
        !wb_ack_o |-> wb_dat_o == '0)
        else $error("read data not zero outside ack");
    a_ps_readback: assert property (@(posedge sys_clk) disable iff (!nrst)
        rd_acc |=> wb_dat_o[PS_MSB:PS_LSB] == $past(shadow_reg))
        else $error("postscale shadow readback wrong");
    a_win_readback: assert property (@(posedge sys_clk) disable iff (!nrst)
        rd_acc |=> wb_dat_o[WIN_BIT] == $past(win_reg))
        else $error("window bit readback wrong");
    a_clear_reads_zero: assert property (@(posedge sys_clk) disable iff (!nrst)
        wb_ack_o |-> !wb_dat_o[CLR_BIT])
        else $error("clear bit read back nonzero");
    a_enable_hold: assert property (@(posedge sys_clk) disable iff (!nrst)
        !wr_acc |=> $stable(sw_on_reg))
        else $error("software enable changed without a write");
    a_window_hold: assert property (@(posedge sys_clk) disable iff (!nrst)
        !wr_acc |=> $stable(win_reg))
        else $error("window bit changed without a write");
    a_expire_reset: assert property (@(posedge sys_clk) disable iff (!nrst)
        watchdog_enabled && tick && !clear_req && count_reg >= period - 1 |=> reset_request)
        else $error("expiry did not request reset");
    a_early_clear: assert property (@(posedge sys_clk) disable iff (!nrst)
        clear_req && watchdog_enabled && win_reg && count_reg < win_open |=> reset_request)
        else $error("early window clear not caught");

    // ************************************************************
    // Watchdog checks
    // ************************************************************
    // Disabled watchdog must not carry a stale count into the next enable
    a_off_count_zero: assert property (@(posedge sys_clk) disable iff (!nrst)
        !watchdog_enabled |=> count_reg == 0)
        else $error("count kept running while disabled");
    a_req_sticky: assert property (@(posedge sys_clk) disable iff (!nrst)
        reset_request |=> reset_request)
        else $error("reset request dropped before reset");
    // Count never passes the period, so expiry is seen on the right tick
    a_count_bounded: assert property (@(posedge sys_clk) disable iff (!nrst)
        count_reg < period)
        else $error("count ran past the period");
endmodule

// ### tb/watchdog_control_logic_tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_mismatch++; \
    $display("[ERR] %0t got %h exp %h", $time, (a), (b)); end end
module watchdog_control_logic_tb;
    import watchdog_pkg::*;
    // ************************************************************
    // Stimulus and design
    // ************************************************************
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    wb_req_s req = '0;
    logic [DAT_W-1:0] wb_dat_o;
    logic wb_ack_o;
    logic config_enable = 1'b0;
    logic [PS_W-1:0] configured_postscale = 5'h00;
    logic watchdog_enabled;
    logic window_mode;
    logic reset_request;
    logic [DAT_W-1:0] q;
    int n_mismatch = 0;
    int checks_done = 0;
    always #2.5 sys_clk = ~sys_clk;
    // Short time base keeps each expiry within a few dozen cycles
    watchdog_control_logic #(.TICK_CYCLES_P(4)) watchdog_control_logic_inst (
        .sys_clk(sys_clk), .nrst(nrst), .wb_req(req), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .config_enable(config_enable),
        .configured_postscale(configured_postscale), .watchdog_enabled(watchdog_enabled),
        .window_mode(window_mode), .reset_request(reset_request));
    // ************************************************************
    // Tasks
    // ************************************************************
    task automatic results();
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic bus(input logic we, input logic [7:0] a, input logic [3:0] s,
                       input logic [31:0] d);
        int i;
        @(posedge sys_clk);
        req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: s, dat: d};
        i = 0;
        do begin
            @(posedge sys_clk);
            i++;
        end while (wb_ack_o !== 1'b1 && i < 50);
        if (i >= 50) begin
            n_mismatch++;
            results();
        end
        q = wb_dat_o;
        req <= '0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
        bus(1'b1, a, s, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp_v);
        bus(1'b0, a, 4'hF, 32'h00000000);
        `CHK(q, exp_v)
    endtask
    task automatic do_reset(input logic [4:0] ps);
        nrst <= 1'b0;
        configured_postscale <= ps;
        config_enable <= 1'b0;
        repeat (3) @(posedge sys_clk);
        nrst <= 1'b1;
        @(posedge sys_clk);
    endtask
    // Bounded wait for the sticky reset request
    task automatic wait_req(input int n);
        int i;
        for (i = 0; i < n && reset_request !== 1'b1; i++) @(posedge sys_clk);
        if (reset_request !== 1'b1) begin
            n_mismatch++;
            results();
        end
    endtask
    // ************************************************************
    // Scenarios
    // ************************************************************
    initial begin
        do_reset(5'h03);
        rd(8'h00, 32'h0000000C);
        wr(8'h00, 4'hF, 32'hFFFFFFFE);
        rd(8'h00, 32'h0000800E);
        `CHK(window_mode, 1'b1)
        `CHK(watchdog_enabled, 1'b1)
        wr(8'h00, 4'hF, 32'h00000000);
        @(posedge sys_clk); // Idle cycle after disabling
        rd(8'h00, 32'h0000000C);
        `CHK(watchdog_enabled, 1'b0)
        wr(8'h00, 4'h1, 32'h00008000);
        rd(8'h00, 32'h0000000C);
        config_enable <= 1'b1;
        wr(8'h00, 4'hF, 32'h00000000);
        rd(8'h00, 32'h0000800C);
        `CHK(watchdog_enabled, 1'b1)
        do_reset(5'h03);
        wr(8'h04, 4'hF, 32'hFFFFFFFF);
        rd(8'h04, 32'h00000000);
        rd(8'h00, 32'h0000000C);
        // Period is 8 ticks of 4 cycles; clears every 3 cycles outlast it
        wr(8'h00, 4'hF, 32'h00008000);
        repeat (16) wr(8'h00, 4'hF, 32'h00008001);
        `CHK(reset_request, 1'b0)
        repeat (4) wr(8'h00, 4'hF, 32'h00008000);
        wait_req(40);
        `CHK(reset_request, 1'b1)
        do_reset(5'h00);
        wr(8'h00, 4'hF, 32'h00008000);
        wait_req(8);
        `CHK(reset_request, 1'b1)
        do_reset(5'h03);
        wr(8'h00, 4'hF, 32'h00008002);
        `CHK(reset_request, 1'b0)
        wr(8'h00, 4'hF, 32'h00008003);
        wait_req(3);
        `CHK(reset_request, 1'b1)
        do_reset(5'h03);
        wr(8'h00, 4'hF, 32'h00008002);
        // Clear lands in the last quarter of the 8-tick period
        repeat (25) @(posedge sys_clk);
        wr(8'h00, 4'hF, 32'h00008003);
        `CHK(reset_request, 1'b0)
        results();
    end
endmodule
